/* verilog/rtcam_alarm0.sv */
`timescale 1ns/1ps
// Summary of operation
// - Field bit 7 enables that field's compare.
// - Minutes target is BCD below enable.
// - Hours, date, month targets also BCD.
// - Alarm interrupts only with enable bit 5.
// - Mode bit 7 zero gives single event.
// - Match when counters advance into target.
// - Match sets status flag, drives output low.
// - Mode one pulses output every match.
// - Seconds-only target 30 fires each minute.
// - Pulsed mode sets flag, needs no clear.
module rtcam_alarm0 #(
  parameter int PULSE_LEN = rtcam_pkg::PULSE_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire rtcam_pkg::rtcam_regreq_t regReq,
  output logic [7:0] regRdata_q,
  input wire rtcam_pkg::rtcam_time_t timeNow,
  input wire logic timeTick,
  output logic irqOut_q,
  output logic irqOe_q
);
  import rtcam_pkg::*;

  // ========================================================================
  // Register file
  // ========================================================================

  // Alarm field registers, index 0 is seconds.
  logic [NUM_FIELDS-1:0][7:0] alarm_q;
  logic [NUM_FIELDS-1:0][7:0] alarm_d;
  // Interrupt control register.
  logic [7:0] intCtl_q;
  logic [7:0] intCtl_d;
  // Alarm 0 status flag.
  logic statusFlag_q;
  logic statusFlag_d;
  // Read data next value.
  logic [7:0] regRdata_d;
  // Decoded control bits.
  logic alarmEn;
  logic pulseMode;
  // Software clear request for the status flag.
  logic statusClr;
  // Match result.
  logic alarmFire;

  assign alarmEn = intCtl_q[ALARM0_ENABLE_BIT];
  assign pulseMode = intCtl_q[INTERRUPT_MODE_SELECT_BIT];
  // Writing zero to the flag position clears the flag.
  assign statusClr = regReq.wr && (regReq.addr == ADDR_STATUS) &&
                     !regReq.data[ALARM0_STATUS_FLAG_BIT];

  // Next values of the registers and the read data.
  always_comb begin
    alarm_d = alarm_q;
    intCtl_d = intCtl_q;
    // Writes to the field registers store the full byte.
    if (regReq.wr && (regReq.addr < ADDR_INTERRUPT_CONTROL)) begin
      alarm_d[regReq.addr] = regReq.data;
    end
    if (regReq.wr && (regReq.addr == ADDR_INTERRUPT_CONTROL)) begin
      intCtl_d = regReq.data;
    end
    // A match in the clearing cycle wins over the clear.
    // flag set on match
    if (alarmFire) begin
      statusFlag_d = 1'b1;
    end else if (statusClr) begin
      statusFlag_d = 1'b0;
    end else begin
      statusFlag_d = statusFlag_q;
    end
    // Read data is registered each cycle from the addressed register.
    if (regReq.addr < ADDR_INTERRUPT_CONTROL) begin
      regRdata_d = alarm_q[regReq.addr];
    end else if (regReq.addr == ADDR_INTERRUPT_CONTROL) begin
      regRdata_d = intCtl_q;
    end else begin
      regRdata_d = 8'h00;
      regRdata_d[ALARM0_STATUS_FLAG_BIT] = statusFlag_q;
    end
  end

  // Register storage.
  // All registers load every cycle from their next values, so a write lands at the
  // same edge that the decoder presents it.
  // A clear of the status flag and a match in the same cycle leave the flag set,
  // so a host that clears too late never loses an interrupt.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      // Every alarm field comes up disabled, so nothing can match after reset.
      alarm_q <= {NUM_FIELDS{ALARM_RESET}};
      intCtl_q <= INTCTL_RESET;
      statusFlag_q <= 1'b0;
      regRdata_q <= 8'h00;
    end else begin
      alarm_q <= alarm_d;
      intCtl_q <= intCtl_d;
      statusFlag_q <= statusFlag_d;
      regRdata_q <= regRdata_d;
    end
  end

  // ========================================================================
  // Match logic
  // ========================================================================

  // Per-field hit: disabled fields always hit.
  logic [NUM_FIELDS-1:0] fieldHit;
  // Per-field enable bits.
  logic [NUM_FIELDS-1:0] fieldEn;

  // One comparator per field.
  // The comparison is a plain equality of BCD digits, so no binary conversion is
  // needed and a target that is not valid BCD simply never matches.
  // A disabled field reports a hit so that it drops out of the AND below.
  for (genvar i = 0; i < NUM_FIELDS; i++) begin : g_field
    assign fieldEn[i] = alarm_q[i][FIELD_EN_BIT];
    assign fieldHit[i] = !fieldEn[i] ||
                         (alarm_q[i][BCD_W-1:0] == timeNow.field[i]);
  end

  // The tick marks the cycle in which the counters hold their new value.
  // Matching only on the tick keeps a time that stands still at the target from
  // firing again on every clock, and makes writes to the targets harmless until
  // the counters next advance.
  // With every field disabled the alarm never fires, rather than firing each tick.
  // fire on advance
  assign alarmFire = timeTick && alarmEn && (|fieldEn) && (&fieldHit);

  // ========================================================================
  // Interrupt output
  // ========================================================================

  // Output state and pulse counter.
  rtcam_state_t state_q;
  rtcam_state_t state_d;
  logic [15:0] pulseCnt_q;
  logic [15:0] pulseCnt_d;

  // Next state of the interrupt output.
  // Idle leaves the pin released; held keeps it low until the flag is cleared;
  // pulse keeps it low for a fixed number of cycles and then releases it.
  // The flag is not consulted in pulse mode, so periodic alarms keep coming
  // whether or not the host services them.
  always_comb begin
    state_d = state_q;
    pulseCnt_d = pulseCnt_q;
    unique case (state_q)
      IRQ_IDLE: begin
        // Nothing is driven until a match.
      end
      IRQ_HELD: begin
        if (!statusFlag_d) begin
          state_d = IRQ_IDLE;
        end
      end
      IRQ_PULSE: begin
        if (pulseCnt_q <= 16'h0001) begin
          state_d = IRQ_IDLE;
        end else begin
          pulseCnt_d = pulseCnt_q - 16'h0001;
        end
      end
    endcase
    // A new match restarts the output whatever the current state.
    if (alarmFire) begin
      if (pulseMode) begin
        state_d = IRQ_PULSE;
        pulseCnt_d = 16'(PULSE_LEN);
      end else begin
        state_d = IRQ_HELD;
      end
    end
  end

  // State registers and the open-drain drive.
  // The enable is taken from the next state so that the pin follows the state
  // register in the same cycle, with no extra cycle of latency.
  // The data bit is always low: the pin is only ever pulled down, never driven high.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= IRQ_IDLE;
      pulseCnt_q <= 16'h0000;
      irqOe_q <= 1'b0;
      irqOut_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pulseCnt_q <= pulseCnt_d;
      irqOe_q <= (state_d != IRQ_IDLE);
      irqOut_q <= 1'b0;
    end
  end

  // ========================================================================
  // Assertions
  // ========================================================================

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  chk_field_enable: assert property (
    alarmFire && fieldEn[0] |-> alarm_q[0][BCD_W-1:0] == timeNow.field[0])
    else $error("Fired with enabled seconds mismatch.");

  chk_minutes_bcd: assert property (
    alarmFire && fieldEn[1] |-> alarm_q[1][BCD_W-1:0] == timeNow.field[1])
    else $error("Fired with enabled minutes mismatch.");

  chk_hours_bcd: assert property (
    alarmFire && fieldEn[2] |-> alarm_q[2][BCD_W-1:0] == timeNow.field[2])
    else $error("Fired with enabled hours mismatch.");

  chk_date_bcd: assert property (
    alarmFire && fieldEn[3] |-> alarm_q[3][BCD_W-1:0] == timeNow.field[3])
    else $error("Fired with enabled date mismatch.");

  chk_month_bcd: assert property (
    alarmFire && fieldEn[4] |-> alarm_q[4][BCD_W-1:0] == timeNow.field[4])
    else $error("Fired with enabled month mismatch.");

  chk_weekday_match: assert property (
    alarmFire && fieldEn[5] |-> alarm_q[5][BCD_W-1:0] == timeNow.field[5])
    else $error("Fired with enabled weekday mismatch.");

  chk_no_fields: assert property (
    timeTick && !(|fieldEn) && state_q == IRQ_IDLE |=> !irqOe_q)
    else $error("Interrupt driven with every field disabled.");

  chk_enable_gate: assert property (
    !alarmEn && state_q == IRQ_IDLE |=> !irqOe_q)
    else $error("Interrupt driven with alarm disabled.");

  chk_single_mode: assert property (
    alarmFire && !pulseMode |=> state_q == IRQ_HELD && irqOe_q)
    else $error("Single event mode did not hold.");

  chk_tick_only: assert property (
    !timeTick && state_q == IRQ_IDLE |=> state_q == IRQ_IDLE)
    else $error("Match declared without counter advance.");

  chk_fire_effects: assert property (
    alarmFire |=> statusFlag_q && irqOe_q && !irqOut_q)
    else $error("Match did not set flag and drive output.");

  chk_pulse_width: assert property (
    alarmFire && pulseMode && PULSE_LEN >= 8 |=> irqOe_q [*8])
    else $error("Periodic pulse shorter than expected.");

  chk_pulse_ends: assert property (
    state_q == IRQ_PULSE && pulseCnt_q == 16'h0001 && !alarmFire
    |=> state_q == IRQ_IDLE && !irqOe_q)
    else $error("Periodic pulse did not end.");

  chk_pulse_flag: assert property (
    alarmFire && pulseMode |=> statusFlag_q && state_q == IRQ_PULSE)
    else $error("Pulsed match did not set flag.");

  chk_held_low: assert property (
    state_q == IRQ_HELD && statusFlag_q && !statusClr |=> irqOe_q)
    else $error("Single event output released early.");

  cov_single: cover property (alarmFire && !pulseMode ##[1:50] statusClr);
  cov_pulse: cover property (alarmFire && pulseMode ##[1:50] state_q == IRQ_IDLE);
  cov_set_clear: cover property (alarmFire && statusClr);
  cov_pulse_again: cover property (alarmFire && pulseMode ##[1:200] alarmFire && pulseMode);
  cov_held_long: cover property (state_q == IRQ_HELD ##8 state_q == IRQ_HELD);

endmodule : rtcam_alarm0

/* verilog/rtcam_pkg.sv */
// ==========================================================================
// Shared constants and types for the alarm 0 match block.
// ==========================================================================
package rtcam_pkg;

  // Number of alarm fields: seconds, minutes, hours, date, month, weekday.
  localparam int NUM_FIELDS = 6;
  // Width of one BCD time value as compared against a target.
  localparam int BCD_W = 7;
  // Width of the local register address.
  localparam int ADDR_W = 3;

  // Register offsets on the local register port.
  localparam logic [2:0] ADDR_ALARM0_SECONDS = 3'h0;
  localparam logic [2:0] ADDR_ALARM0_MINUTES = 3'h1;
  localparam logic [2:0] ADDR_ALARM0_HOURS = 3'h2;
  localparam logic [2:0] ADDR_ALARM0_DATE = 3'h3;
  localparam logic [2:0] ADDR_ALARM0_MONTH = 3'h4;
  localparam logic [2:0] ADDR_ALARM0_WEEKDAY = 3'h5;
  localparam logic [2:0] ADDR_INTERRUPT_CONTROL = 3'h6;
  localparam logic [2:0] ADDR_STATUS = 3'h7;

  // Field positions.
  localparam int FIELD_EN_BIT = 7;
  localparam int ALARM0_ENABLE_BIT = 5;
  localparam int INTERRUPT_MODE_SELECT_BIT = 7;
  localparam int ALARM0_STATUS_FLAG_BIT = 5;

  // Reset values.
  localparam logic [7:0] ALARM_RESET = 8'h00;
  localparam logic [7:0] INTCTL_RESET = 8'h00;

  // Pulse width of the periodic interrupt, and the clock period.
  localparam int PULSE_TIME_NS = 1000;
  localparam int CLK_PERIOD_NS = 100;
  // Longest time rounds down, never below one cycle.
  localparam int PULSE_CYCLES = (PULSE_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                (PULSE_TIME_NS / CLK_PERIOD_NS);

  // Current time from the timekeeping counters, index 0 is seconds.
  typedef struct packed {
    logic [NUM_FIELDS-1:0][BCD_W-1:0] field;
  } rtcam_time_t;

  // One register access from the serial interface decoder.
  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } rtcam_regreq_t;

  // Interrupt output states.
  typedef enum logic [1:0] {
    IRQ_IDLE,
    IRQ_HELD,
    IRQ_PULSE
  } rtcam_state_t;

endpackage : rtcam_pkg

/* tb/rtcam_host_model.sv */
`timescale 1ns/1ps
// ==========================================
// Host side of the open-drain alarm line.
// ==========================================
module rtcam_host_model (
  input wire logic mclk,
  input wire logic irqOut,
  input wire logic irqOe,
  output logic irqPin,
  output int irqCount
);
  // The board pull-up holds the line high while nobody drives it.
  assign irqPin = irqOe ? irqOut : 1'b1;
  initial irqCount = 0;
  // Count each falling edge of the line as one interrupt seen by the host.
  always @(negedge irqPin) begin
    irqCount = irqCount + 1;
  end
endmodule : rtcam_host_model

/* tb/rtc_alarm0_match_tb.sv */
`timescale 1ns/1ps
// ==========================================
// Bench for the alarm 0 match block.
// ==========================================
module rtc_alarm0_match_tb;
  import rtcam_pkg::*;
  localparam int PL = 8;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  rtcam_regreq_t regReq = '0;
  rtcam_time_t timeNow = '0;
  logic timeTick = 1'b0;
  logic [7:0] regRdata_q;
  logic irqOut_q;
  logic irqOe_q;
  logic irqPin;
  logic [7:0] rv;
  int irqCount;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_count++; \
  $display("Error at %0t: got %h want %h", $time, (a), (e)); end end
  // 10 MHz clock.
  always #50 mclk = ~mclk;
  rtcam_alarm0 #(.PULSE_LEN(PL)) DUT (.mclk(mclk), .rst(rst), .regReq(regReq),
    .regRdata_q(regRdata_q), .timeNow(timeNow), .timeTick(timeTick),
    .irqOut_q(irqOut_q), .irqOe_q(irqOe_q));
  rtcam_host_model host (.mclk(mclk), .irqOut(irqOut_q), .irqOe(irqOe_q),
    .irqPin(irqPin), .irqCount(irqCount));
  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict;
    $display("Checks %0d, errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict
  // One write strobe, taken at the second edge.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk) regReq <= '{wr: 1'b1, addr: a, data: d};
    @(posedge mclk) regReq <= '{wr: 1'b0, addr: a, data: d};
  endtask : wr
  // Read data shows one cycle after the address is presented.
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk) regReq <= '{wr: 1'b0, addr: a, data: 8'h00};
    @(posedge mclk);
    #1 d = regRdata_q;
  endtask : rd
  // Advances the time to t with a one-cycle tick, returns at the sampling edge.
  task automatic tick(input logic [41:0] t);
    @(posedge mclk) begin
      timeNow <= t;
      timeTick <= 1'b1;
    end
    @(posedge mclk) timeTick <= 1'b0;
    #1;
  endtask : tick
  // Cuts a hang short.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0], rv);
      `CHK(rv, 8'h00)
    end
    // Single event: 11:30 with seconds not compared, on the first of the first month.
    wr(ADDR_ALARM0_SECONDS, 8'h00);
    wr(ADDR_ALARM0_MINUTES, 8'hb0);
    wr(ADDR_ALARM0_HOURS, 8'h91);
    wr(ADDR_ALARM0_DATE, 8'h81);
    wr(ADDR_ALARM0_MONTH, 8'h81);
    wr(ADDR_ALARM0_WEEKDAY, 8'h00);
    rd(ADDR_ALARM0_MINUTES, rv);
    `CHK(rv, 8'hb0)
    rd(ADDR_ALARM0_HOURS, rv);
    `CHK(rv, 8'h91)
    tick({7'h03, 7'h01, 7'h01, 7'h11, 7'h30, 7'h00});
    `CHK(irqOe_q, 1'b0)
    wr(ADDR_INTERRUPT_CONTROL, 8'h20);
    tick({7'h03, 7'h01, 7'h01, 7'h11, 7'h29, 7'h59});
    `CHK(irqOe_q, 1'b0)
    tick({7'h05, 7'h01, 7'h01, 7'h11, 7'h30, 7'h00});
    `CHK(irqPin, 1'b0)
    repeat (3 * PL) @(posedge mclk);
    #1 `CHK(irqOe_q, 1'b1)
    rd(ADDR_STATUS, rv);
    `CHK(rv, 8'h20)
    `CHK(irqOe_q, 1'b1)
    wr(ADDR_STATUS, 8'h00);
    #1 `CHK(irqPin, 1'b1)
    // Pulsed mode, seconds only at 30.
    wr(ADDR_ALARM0_SECONDS, 8'hb0);
    for (int a = 1; a < 6; a++) wr(a[2:0], 8'h00);
    wr(ADDR_INTERRUPT_CONTROL, 8'ha0);
    n = irqCount;
    for (int k = 0; k < 3; k++) begin
      tick({7'h03, 7'h01, 7'h01, 7'h11, k[6:0], 7'h30});
      n = 0;
      while (irqOe_q === 1'b1 && n < 50) begin
        n++;
        @(posedge mclk);
        #1;
      end
      `CHK(n, PL)
      tick({7'h03, 7'h01, 7'h01, 7'h11, k[6:0], 7'h31});
      `CHK(irqOe_q, 1'b0)
    end
    rd(ADDR_STATUS, rv);
    `CHK(rv, 8'h20)
    `CHK(irqCount, 4)
    give_verdict();
  end
endmodule : rtc_alarm0_match_tb
